// ---- hdl/bpsd_evt_if.sv ----
/*
 * Carrier between the register core and the interrupt block.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface bpsd_evt_if;
    logic [bpsd_pkg::NEV-1:0] ev;
    logic                     wr_stat;
    logic                     wr_mask;
    logic [bpsd_pkg::NEV-1:0] wdata;
    logic [bpsd_pkg::NEV-1:0] stat;
    logic [bpsd_pkg::NEV-1:0] mask;

    modport core (output ev, output wr_stat, output wr_mask, output wdata,
                  input stat, input mask);
    modport irq  (input ev, input wr_stat, input wr_mask, input wdata,
                  output stat, output mask);
endinterface

`default_nettype wire

// ---- hdl/bpsd_irq.sv ----
/*
 * Sticky interrupt status with write-one-to-clear, mask and one level output.
 * Assumes event pulses and write strobes come from the register core.
 */
`timescale 1ns/1ps
`default_nettype none

module bpsd_irq (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    bpsd_evt_if.irq   evt,
    output logic      irq
);

    typedef struct packed {
        logic [bpsd_pkg::NEV-1:0] stat;
        logic [bpsd_pkg::NEV-1:0] mask;
    } bpsd_irq_st_t;

    bpsd_irq_st_t st_r;
    bpsd_irq_st_t st_nxt;

    // Events set status; a set in the clearing cycle wins
    always_comb
    begin
        st_nxt = st_r;
        if (evt.wr_stat)
        begin
            st_nxt.stat = st_r.stat & ~evt.wdata;
        end
        st_nxt.stat = st_nxt.stat | evt.ev;
        if (evt.wr_mask)
        begin
            st_nxt.mask = evt.wdata;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{stat: bpsd_pkg::EV_RESET, mask: bpsd_pkg::EV_RESET};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Read back and level output
    assign evt.stat = st_r.stat;
    assign evt.mask = st_r.mask;
    assign irq      = |(st_r.stat & st_r.mask);

endmodule // bpsd_irq

`default_nettype wire

// ---- hdl/bpsd_pkg.sv ----
/*
 * Constants, offsets and helpers for the bridge power state and decode registers.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
package bpsd_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFF_PMCS      = 8'h94;
    localparam logic [7:0]  OFF_SDEC      = 8'h98;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'hC0;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'hC4;

    // Power state codes
    localparam logic [1:0]  PS_D0         = 2'h0;
    localparam logic [1:0]  PS_D1         = 2'h1;
    localparam logic [1:0]  PS_D2         = 2'h2;
    localparam logic [1:0]  PS_D3         = 2'h3;
    localparam logic [1:0]  PS_RESET      = PS_D0;

    // Field positions in the control/status word
    localparam int          PS_LSB        = 0;
    localparam int          PS_MSB        = 1;
    localparam int          NSR_BIT       = 3;
    localparam int          PME_EN_BIT    = 8;
    localparam int          PME_ST_BIT    = 15;
    localparam logic        NSR_VALUE     = 1'b1;
    localparam logic        B2B3_VALUE    = 1'b0;
    localparam logic        BPCC_VALUE    = 1'b0;
    localparam int          B2B3_BIT      = 22;
    localparam int          BPCC_BIT      = 23;

    // Field positions in the decode register
    localparam int          SUB_EN_BIT    = 0;
    localparam int          SUB_DEC_BIT   = 1;

    // Class codes
    localparam logic [23:0] CLASS_SUB     = 24'h060401;
    localparam logic [23:0] CLASS_STD     = 24'h060400;

    // Interrupt events
    localparam int          NEV           = 3;
    localparam int          EV_PME        = 0;
    localparam int          EV_WAKE       = 1;
    localparam int          EV_BADPS      = 2;
    localparam logic [NEV-1:0] EV_RESET   = 3'h0;

    // Expands byte enables into a bit mask
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // True when a power state code is implemented
    function automatic logic ps_valid(input logic [1:0] ps);
        ps_valid = (ps == PS_D0) || (ps == PS_D3);
    endfunction

endpackage

// ---- hdl/bpsd_regs.sv ----
/*
 * Power management control/status, bridge support extension and subtractive
 * decode control of a PCIe-to-PCI bridge, reached over classic Wishbone.
 * Assumes synchronous inputs on clk_sys and an asynchronous active-low reset.
 * Assumes a master that holds each request until it samples ack and then
 * releases it for at least one cycle.
 * Configuration accesses come from the upstream host through this port only.
 * Byte lane 0 carries the power state, the decode bits and the interrupt
 * words; byte lane 1 carries the event enable and the event status.
 * Bits 31:16 at the control/status offset hold the read-only extension word.
 * Unmapped offsets answer with zero and ignore writes.
 * The internal reset pulse is for the bridge datapath; this block keeps its
 * own registers across it, which is why bit 3 reads one.
 */
// Added by the designer: the Wishbone register port.
// Summary of operation
// - Power state field: 00 is D0, 11 is D3; resets to D0.
// - Writes of codes 01 or 10 to power state are ignored.
// - Software D3 to D0 change pulses internal reset, bus reset output stays off.
// - Bit 3 reads one: registers preserved across D3hot to D0.
// - Bit 8 enables event output; when zero the output never asserts.
// - Data select, data scale and data byte always read zero.
// - Extension bit 22 reads zero: no B2/B3 support.
// - Extension bit 23 reads zero: bus power/clock control disabled.
// - Decode bit 0 gives class 060401h and forwards all memory and I/O.
// - Decode bit 0 hides capability and extended registers: writes dropped, reads zero.
// - Decode bit 1 enables subtractive claiming on the conventional bus; resets zero.
// - Event output works in D0, D3hot and D3cold alike.
`timescale 1ns/1ps
`default_nettype none

module bpsd_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,

    // Classic Wishbone slave port
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,

    // Power-management event request and open-drain pin
    input  wire logic        pme_req,
    output logic             pme_o,
    output logic             pme_oe_n,

    // Internal reset pulse and bus reset
    output logic             soft_rst_o,
    output logic             bus_rst_out_n,

    // Mode outputs to the bridge datapath
    output logic      [1:0]  power_state,
    output logic      [23:0] class_code,
    output logic             fwd_all,
    output logic             ext_cfg_hide,
    output logic             sub_decode_en,

    // Level interrupt
    output logic             irq
);

    // Core state: register fields plus the registered bus answer
    typedef struct packed {
        logic [1:0]  ps;
        logic        pme_en;
        logic        pme_st;
        logic        sub_en;
        logic        sub_dec;
        logic        soft_rst;
        logic        ack;
        logic [31:0] dat;
    } bpsd_core_st_t;

    bpsd_core_st_t st_r;
    bpsd_core_st_t st_nxt;

    // Carrier toward the interrupt block
    bpsd_evt_if evt ();

    // Decoded bus request and write data
    logic        req;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] wval;

    // Read words of the two control registers
    logic [31:0] pmcs_word;
    logic [31:0] sdec_word;

    // Power state write, its legality and the gated event
    logic        ps_wr;
    logic        ps_ok;
    logic        pme_sig;

    // Write strobes: lanes 0 and 1 of the control/status word, lane 0 of the other registers
    logic        pm_lo_wr;
    logic        pm_hi_wr;
    logic        sdec_wr;
    logic        stat_wr;
    logic        mask_wr;

    // Write strobe for one byte lane of one register offset
    function automatic logic lane_wr(input logic       w,
                                     input logic [7:0] adr,
                                     input logic [7:0] off,
                                     input logic       lane);
        lane_wr = w && (adr == off) && lane;
    endfunction

    // Widens an interrupt word to the bus width, upper bits zero
    function automatic logic [31:0] pad_ev(input logic [bpsd_pkg::NEV-1:0] v);
        pad_ev = 32'h0000_0000;
        pad_ev[bpsd_pkg::NEV-1:0] = v;
    endfunction

    // Bus request decode; ack rises one cycle after the request
    // A request is not taken while its ack stands, so a master that still
    // holds the strobe in the ack cycle is answered only once
    assign req   = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign wr    = req && wb_we_i;
    assign wmask = bpsd_pkg::byte_mask(wb_sel_i);
    assign wval  = wb_dat_i & wmask;

    // Write strobes per register and lane
    assign pm_lo_wr = lane_wr(wr, wb_adr_i, bpsd_pkg::OFF_PMCS, wb_sel_i[0]);
    assign pm_hi_wr = lane_wr(wr, wb_adr_i, bpsd_pkg::OFF_PMCS, wb_sel_i[1]);
    assign sdec_wr  = lane_wr(wr, wb_adr_i, bpsd_pkg::OFF_SDEC, wb_sel_i[0]);
    assign stat_wr  = lane_wr(wr, wb_adr_i, bpsd_pkg::OFF_IRQ_STAT, wb_sel_i[0]);
    assign mask_wr  = lane_wr(wr, wb_adr_i, bpsd_pkg::OFF_IRQ_MASK, wb_sel_i[0]);

    // Power state write and its legality
    assign ps_wr = pm_lo_wr;
    assign ps_ok = bpsd_pkg::ps_valid(wb_dat_i[bpsd_pkg::PS_MSB:bpsd_pkg::PS_LSB]);

    // Event signalled only while enabled, in any power state
    // The power state is not part of the gate, so D0 and D3 behave alike
    assign pme_sig = pme_req && st_r.pme_en;

    // Control/status and extension read word
    // Data select, data scale and data byte stay zero: no data register
    always_comb
    begin
        pmcs_word = 32'h0000_0000;
        pmcs_word[bpsd_pkg::PS_MSB:bpsd_pkg::PS_LSB] = st_r.ps;
        pmcs_word[bpsd_pkg::NSR_BIT] = bpsd_pkg::NSR_VALUE;
        pmcs_word[bpsd_pkg::PME_EN_BIT] = st_r.pme_en;
        pmcs_word[bpsd_pkg::PME_ST_BIT] = st_r.pme_st;
        pmcs_word[bpsd_pkg::B2B3_BIT] = bpsd_pkg::B2B3_VALUE;
        pmcs_word[bpsd_pkg::BPCC_BIT] = bpsd_pkg::BPCC_VALUE;
    end

    // Decode control read word
    always_comb
    begin
        sdec_word = 32'h0000_0000;
        sdec_word[bpsd_pkg::SUB_EN_BIT] = st_r.sub_en;
        sdec_word[bpsd_pkg::SUB_DEC_BIT] = st_r.sub_dec;
    end

    // Next state of the register core
    always_comb
    begin
        st_nxt = st_r;
        // Every taken request is answered once, one cycle later
        st_nxt.ack = req;
        // The internal reset lasts exactly one cycle
        st_nxt.soft_rst = 1'b0;

        // Power state: illegal codes leave the field untouched
        if (ps_wr && ps_ok)
        begin
            st_nxt.ps = wb_dat_i[bpsd_pkg::PS_MSB:bpsd_pkg::PS_LSB];
            // Leaving D3 for D0 pulses the datapath reset only
            if ((st_r.ps == bpsd_pkg::PS_D3) &&
                (wb_dat_i[bpsd_pkg::PS_MSB:bpsd_pkg::PS_LSB] == bpsd_pkg::PS_D0))
            begin
                st_nxt.soft_rst = 1'b1;
            end
        end

        // Enable bit and write-one-to-clear status
        // The set below comes after the clear, so an event in the clearing
        // cycle wins and is never lost
        if (pm_hi_wr)
        begin
            st_nxt.pme_en = wb_dat_i[bpsd_pkg::PME_EN_BIT];
            if (wb_dat_i[bpsd_pkg::PME_ST_BIT])
            begin
                st_nxt.pme_st = 1'b0;
            end
        end
        if (pme_sig)
        begin
            st_nxt.pme_st = 1'b1;
        end

        // Decode control bits
        // Bridge mode switches class code, forwarding and hiding together
        if (sdec_wr)
        begin
            st_nxt.sub_en = wb_dat_i[bpsd_pkg::SUB_EN_BIT];
            st_nxt.sub_dec = wb_dat_i[bpsd_pkg::SUB_DEC_BIT];
        end

        // Read data, registered with the ack
        // Unmapped reads and all writes return zero data
        if (req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                bpsd_pkg::OFF_PMCS:     st_nxt.dat = pmcs_word;
                bpsd_pkg::OFF_SDEC:     st_nxt.dat = sdec_word;
                bpsd_pkg::OFF_IRQ_STAT: st_nxt.dat = pad_ev(evt.stat);
                bpsd_pkg::OFF_IRQ_MASK: st_nxt.dat = pad_ev(evt.mask);
                default:                st_nxt.dat = 32'h0000_0000;
            endcase
        end
        else if (req)
        begin
            st_nxt.dat = 32'h0000_0000;
        end
    end

    // State register; every bit returns to its reset value
    // Sticky enable and status clear only here, not on the internal reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{ps:       bpsd_pkg::PS_RESET,
                      pme_en:   1'b0,
                      pme_st:   1'b0,
                      sub_en:   1'b0,
                      sub_dec:  1'b0,
                      soft_rst: 1'b0,
                      ack:      1'b0,
                      dat:      32'h0000_0000};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Events toward the interrupt block
    // The power event follows pme_req while enabled, the others last one cycle; the interrupt block makes them sticky
    always_comb
    begin
        evt.ev = bpsd_pkg::EV_RESET;
        evt.ev[bpsd_pkg::EV_PME] = pme_sig;
        evt.ev[bpsd_pkg::EV_WAKE] = st_nxt.soft_rst;
        evt.ev[bpsd_pkg::EV_BADPS] = ps_wr && !ps_ok;
    end

    // Interrupt register writes
    assign evt.wr_stat = stat_wr;
    assign evt.wr_mask = mask_wr;
    assign evt.wdata   = wval[bpsd_pkg::NEV-1:0];

    // Interrupt status, mask and level output
    bpsd_irq u_irq (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .evt     (evt),
        .irq     (irq)
    );

    // Bus port outputs
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;

    // Open-drain event pin: drives low while status and enable are both set
    // Clearing the enable releases the pin at once, status kept
    assign pme_o    = 1'b0;
    assign pme_oe_n = !(st_r.pme_st && st_r.pme_en);

    // Internal reset pulse; the bus reset output is never asserted
    assign soft_rst_o    = st_r.soft_rst;
    assign bus_rst_out_n = 1'b1;

    // Mode outputs toward the bridge datapath
    // Hiding of capability and extended registers is done by their owner
    // through ext_cfg_hide
    assign power_state   = st_r.ps;
    assign class_code    = st_r.sub_en ? bpsd_pkg::CLASS_SUB : bpsd_pkg::CLASS_STD;
    assign fwd_all       = st_r.sub_en;
    assign ext_cfg_hide  = st_r.sub_en;
    assign sub_decode_en = st_r.sub_dec;

endmodule // bpsd_regs

`default_nettype wire

// ---- verification/bpsd_host.sv ----
/*
 * Upstream host model: issues classic Wishbone configuration cycles.
 * Assumes one clock shared with the register block.
 */
`timescale 1ns/1ps
`default_nettype none

module bpsd_host (
    input  wire logic        clk_sys,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [7:0]  adr,
    output logic      [3:0]  sel,
    output logic      [31:0] dat,
    input  wire logic        ack,
    input  wire logic [31:0] rdat
);
    initial {cyc, stb, we, adr, sel, dat} = '0;

    // One transfer: hold until ack is sampled, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        begin
            n = 0;
            ok = 1'b0;
            @(posedge clk_sys);
            cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
            while (!ok && n < 20)
            begin
                @(posedge clk_sys);
                n++;
                ok = (ack === 1'b1);
            end
            q = rdat;
            cyc <= 1'b0; stb <= 1'b0; dat <= ~d; // Released data no longer shows the value
        end
    endtask
endmodule // bpsd_host

`default_nettype wire

// ---- verification/bpsd_regs_props.sv ----
/*
 * Concurrent checks on the register block ports.
 * Assumes it is bound onto bpsd_regs and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module bpsd_regs_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pme_o,
    input wire logic        pme_oe_n,
    input wire logic        soft_rst_o,
    input wire logic        bus_rst_out_n,
    input wire logic [1:0]  power_state,
    input wire logic [23:0] class_code,
    input wire logic        fwd_all,
    input wire logic        ext_cfg_hide,
    input wire logic        sub_decode_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Write to the control/status word that is taken this edge
    logic ps_wr;
    assign ps_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == 8'h94;
    // Write to the enable and status byte that is taken this edge
    logic pm_hi_wr;
    assign pm_hi_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[1]
                      && wb_adr_i == 8'h94;

    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle answer");
    a_state_legal: assert property (power_state == 2'h0 || power_state == 2'h3)
        else $error("power state holds an unimplemented code");
    a_bad_state_kept: assert property (ps_wr && wb_dat_i[0] != wb_dat_i[1] |=> $stable(power_state))
        else $error("unimplemented state write changed the state");
    a_wake_resets: assert property (ps_wr && wb_dat_i[1:0] == 2'h0 && power_state == 2'h3
                                    |=> soft_rst_o ##1 !soft_rst_o)
        else $error("no single internal reset pulse on wake");
    a_bus_rst_idle: assert property (bus_rst_out_n && !pme_o)
        else $error("bus reset or event data driven");
    a_pmcs_fields: assert property (wb_ack_o && $past(wb_adr_i == 8'h94 && !wb_we_i)
        |-> wb_dat_o[3] && wb_dat_o[31:16] == 16'h0 && wb_dat_o[14:9] == 6'h0
            && wb_dat_o[7:4] == 4'h0 && !wb_dat_o[2])
        else $error("fixed fields of power word wrong");
    a_pme_gated: assert property (wb_ack_o && $past(wb_adr_i == 8'h94 && !wb_we_i)
                                  && !wb_dat_o[8] |-> pme_oe_n)
        else $error("event asserted while disabled");
    a_pme_sticky: assert property (!pme_oe_n && !pm_hi_wr |=> !pme_oe_n)
        else $error("event pin released without a status write");
    a_decode_mode: assert property (class_code == (fwd_all ? 24'h060401 : 24'h060400)
                                    && ext_cfg_hide == fwd_all)
        else $error("class code or hiding disagrees with mode");
    a_decode_read: assert property (wb_ack_o && $past(wb_adr_i == 8'h98 && !wb_we_i)
        |-> wb_dat_o == {30'h0, sub_decode_en, fwd_all})
        else $error("decode register read wrong");
endmodule // bpsd_regs_props

bind bpsd_regs bpsd_regs_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pme_o(pme_o), .pme_oe_n(pme_oe_n),
    .soft_rst_o(soft_rst_o), .bus_rst_out_n(bus_rst_out_n), .power_state(power_state),
    .class_code(class_code), .fwd_all(fwd_all), .ext_cfg_hide(ext_cfg_hide),
    .sub_decode_en(sub_decode_en));

`default_nettype wire

// ---- verification/tb_bridge_power_state_and_decode_regs.sv ----
/*
 * Self-checking bench for the bridge power state and decode registers.
 * Assumes the host model drives the Wishbone port.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_bridge_power_state_and_decode_regs;
    logic clk_sys = 1'b0, rst_n = 1'b0, pme_req = 1'b0;
    logic cyc, stb, we, ack, pme_o, pme_oe_n, soft_rst_o, bus_rst_out_n;
    logic fwd_all, ext_cfg_hide, sub_decode_en, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [1:0] power_state;
    logic [23:0] class_code;
    int fails = 0, num_checks = 0, n_soft = 0;

    always #20 clk_sys = ~clk_sys;
    // Counts internal reset pulses
    always @(posedge clk_sys) if (soft_rst_o) n_soft++;

    bpsd_host host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(wdat), .ack(ack), .rdat(rdat));
    bpsd_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pme_req(pme_req), .pme_o(pme_o), .pme_oe_n(pme_oe_n),
        .soft_rst_o(soft_rst_o), .bus_rst_out_n(bus_rst_out_n), .power_state(power_state),
        .class_code(class_code), .fwd_all(fwd_all), .ext_cfg_hide(ext_cfg_hide),
        .sub_decode_en(sub_decode_en), .irq(irq));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; a missing ack ends the run
    task automatic rw(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        logic ok;
        begin
            host.xfer(w, a, s, d, q, ok);
            if (!ok)
            begin
                fails++;
                tally_and_finish;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        rw(1'b1, a, s, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        begin
            rw(1'b0, a, 4'hF, 32'h0, q);
            chk(q, exp);
        end
    endtask

    // Reset values of the power and decode words, an unmapped word, irq, bus reset and class code
    task automatic t_reset;
        rdc(8'h94, 32'h00000008);
        rdc(8'h98, 32'h00000000);
        rdc(8'h10, 32'h00000000);
        chk({irq, bus_rst_out_n, class_code}, {2'b01, 24'h060400});
    endtask

    // Unimplemented codes are ignored, wake from D3 resets internally
    task automatic t_power;
        wr(8'h94, 4'hF, 32'hFFFF_7EF5);
        rdc(8'h94, 32'h00000008);
        wr(8'h94, 4'h1, 32'h00000003);
        wr(8'h94, 4'h1, 32'h00000002);
        rdc(8'h94, 32'h0000000B);
        chk(n_soft, 0);
        wr(8'h94, 4'h1, 32'h00000000);
        @(posedge clk_sys);
        chk({n_soft[3:0], power_state, bus_rst_out_n}, {4'h1, 2'h0, 1'b1});
    endtask

    // Event gated by enable, sticky status, cleared by a one, works in D3
    task automatic t_pme;
        pme_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        pme_req <= 1'b0;
        chk(pme_oe_n, 1'b1);
        wr(8'h94, 4'h3, 32'h00000103);
        rdc(8'h94, 32'h0000010B);
        pme_req <= 1'b1;
        @(posedge clk_sys);
        pme_req <= 1'b0;
        @(posedge clk_sys);
        chk({pme_oe_n, pme_o}, 2'b00);
        rdc(8'h94, 32'h0000810B);
        wr(8'h94, 4'h2, 32'h00008100);
        rdc(8'h94, 32'h0000010B);
        chk(pme_oe_n, 1'b1);
    endtask

    // Status, mask and level output
    task automatic t_irq;
        chk(irq, 1'b0);
        rdc(8'hC0, 32'h00000007);
        wr(8'hC4, 4'h1, 32'h00000001);
        rdc(8'hC4, 32'h00000001);
        chk(irq, 1'b1);
        wr(8'hC0, 4'h1, 32'h00000007);
        rdc(8'hC0, 32'h00000000);
        chk(irq, 1'b0);
    endtask

    // Subtractive modes and reserved bits
    task automatic t_decode;
        wr(8'h98, 4'hF, 32'hFFFF_FFFF);
        rdc(8'h98, 32'h00000003);
        chk({class_code, fwd_all, ext_cfg_hide, sub_decode_en}, {24'h060401, 3'b111});
        wr(8'h98, 4'hF, 32'h00000002);
        chk({class_code, fwd_all, sub_decode_en}, {24'h060400, 2'b01});
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_power;
        t_pme;
        t_irq;
        t_decode;
        tally_and_finish;
    end
endmodule // tb_bridge_power_state_and_decode_regs

`default_nettype wire
